// file: shared/sos_pkg.sv
// package: constants for the status output selector
package sos_pkg;

  // ----------------------------------------------------------------
  // field widths
  // ----------------------------------------------------------------
  localparam int FUNC_W = 5;               // width of a function select code
  localparam int MODE_W = 2;               // width of the trip output mode
  localparam int VOLT_W = 10;              // dc bus reading, whole volts

  // ----------------------------------------------------------------
  // function select codes
  // ----------------------------------------------------------------
  localparam logic [4:0] FN_OVER_VOLT  = 5'h08;  // dc bus over-voltage
  localparam logic [4:0] FN_LOW_VOLT   = 5'h09;  // low-voltage trip
  localparam logic [4:0] FN_LOST_CMD   = 5'h0B;  // frequency command lost
  localparam logic [4:0] FN_RUN        = 5'h0C;  // running
  localparam logic [4:0] FN_STOP       = 5'h0D;  // stopped
  localparam logic [4:0] FN_STEADY     = 5'h0E;  // steady speed
  localparam logic [4:0] FN_READY      = 5'h10;  // ready for run command
  localparam logic [4:0] FN_TRIP       = 5'h11;  // trip output
  localparam logic [4:0] FN_FAN_WARN   = 5'h12;  // cooling fan warning
  localparam logic [4:0] FN_BRAKE      = 5'h13;  // external brake

  // ----------------------------------------------------------------
  // levels, modes and reset values
  // ----------------------------------------------------------------
  localparam logic [9:0] OVER_VOLT_LEVEL   = 10'h19A; // 410 volts dc
  localparam logic [9:0] UNDER_VOLT_DEFAULT = 10'h0AA; // 170 volts dc
  localparam logic [1:0] TRIP_MODE_NO_LV   = 2'h2;    // any trip but low voltage
  localparam logic       FAN_CONTINUE      = 1'h0;    // keep running on fan fault
  localparam logic       OUT_RESET         = 1'h0;    // output level after reset

endpackage : sos_pkg

// file: src/sos_cond_mux.sv
// module: one selector that maps a function code to an output level
`timescale 1ns/1ns
module sos_cond_mux
  import sos_pkg::*;
(
  input  wire logic [sos_pkg::FUNC_W-1:0] func_sel,      // function select code
  input  wire logic                       over_volt,     // bus above over-voltage level
  input  wire logic                       low_volt_trip, // bus low and lv trip present
  input  wire logic                       lost_cmd,      // command lost
  input  wire logic                       running,       // run cmd and output voltage
  input  wire logic                       steady,        // neither accel nor decel
  input  wire logic                       ready,         // standby and ready
  input  wire logic                       trip_qual,     // trip qualified by mode
  input  wire logic                       fan_warn,      // fan warning qualified
  input  wire logic                       brake,         // external brake set
  output logic                            cond           // selected condition
);

  // ----------------------------------------------------------------
  // selection
  // ----------------------------------------------------------------
  // undefined codes give a low output
  always_comb
  begin
    unique case (func_sel)
      FN_OVER_VOLT: cond = over_volt;
      FN_LOW_VOLT:  cond = low_volt_trip;
      FN_LOST_CMD:  cond = lost_cmd;
      FN_RUN:       cond = running;
      FN_STOP:      cond = ~running;
      FN_STEADY:    cond = running & steady;
      FN_READY:     cond = ready;
      FN_TRIP:      cond = trip_qual;
      FN_FAN_WARN:  cond = fan_warn;
      FN_BRAKE:     cond = brake;
      default:      cond = 1'h0;
    endcase
  end

endmodule : sos_cond_mux

// file: src/sos_selector.sv
// module: status output selector for the relay and the second output
//
// Operation
// - code 8 asserts on bus above 410 V
// - code 9 asserts on low-voltage trip below level
// - code 11 asserts on lost frequency command
// - code 12 asserts while running with voltage output
// - code 13 asserts while drive not running
// - code 14 asserts only in steady speed
// - code 16 asserts when ready for run command
// - code 17 gives trip qualified by trip mode
// - trip mode 2 excludes low-voltage trip
// - code 18 fan warning only when continuing
// - code 19 follows external brake signal
// - relay and output 2 selected independently
`timescale 1ns/1ns
module sos_selector
  import sos_pkg::*;
(
  input  wire logic                       clk,                     // control clock, 20 MHz
  input  wire logic                       rst,                     // sync reset, high
  input  wire logic [sos_pkg::FUNC_W-1:0] relay_function_select,   // relay code
  input  wire logic [sos_pkg::FUNC_W-1:0] output2_function_select, // output 2 code
  input  wire logic [sos_pkg::MODE_W-1:0] trip_output_mode,        // trip qualification
  input  wire logic                       fan_fault_action,        // 0 continue, 1 stop
  input  wire logic [sos_pkg::VOLT_W-1:0] dc_bus_volts,            // bus voltage reading
  input  wire logic [sos_pkg::VOLT_W-1:0] under_volt_level,        // low-voltage level
  input  wire logic                       low_volt_trip,           // lv trip has occurred
  input  wire logic                       other_trip,              // any non-lv trip
  input  wire logic                       lost_cmd,                // command lost
  input  wire logic                       run_cmd,                 // run command present
  input  wire logic                       volt_out,                // producing voltage
  input  wire logic                       accel,                   // accelerating
  input  wire logic                       decel,                   // decelerating
  input  wire logic                       standby_ready,           // ready for run cmd
  input  wire logic                       fan_fault,               // cooling fan fault
  input  wire logic                       brake_set,               // external brake set
  output logic                            relay_out,               // relay drive
  output logic                            multi_output_pin         // second output drive
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic relay;   // relay level
    logic out2;    // second output level
  } sos_state_type;

  sos_state_type st_q;  // registered state
  sos_state_type st_d;  // next state

  // ----------------------------------------------------------------
  // shared conditions
  // ----------------------------------------------------------------
  logic over_volt_c;   // bus above over-voltage level
  logic low_trip_c;    // bus under level with lv trip
  logic running_c;     // run cmd with voltage out
  logic steady_c;      // constant speed
  logic trip_c;        // trip qualified by mode
  logic fan_warn_c;    // fan warning qualified
  logic relay_c;       // relay condition
  logic out2_c;        // output 2 condition

  assign over_volt_c = dc_bus_volts > OVER_VOLT_LEVEL;
  assign low_trip_c  = (dc_bus_volts < under_volt_level) & low_volt_trip;
  assign running_c   = run_cmd & volt_out;
  assign steady_c    = ~accel & ~decel;
  // mode 2 ignores low-voltage trips; other modes count every trip
  assign trip_c      = (trip_output_mode == TRIP_MODE_NO_LV) ? other_trip
                       : (other_trip | low_volt_trip);
  assign fan_warn_c  = fan_fault & (fan_fault_action == FAN_CONTINUE);

  // ----------------------------------------------------------------
  // two independent selectors
  // ----------------------------------------------------------------
  sos_cond_mux u_relay_mux (
    .func_sel      (relay_function_select),
    .over_volt     (over_volt_c),
    .low_volt_trip (low_trip_c),
    .lost_cmd      (lost_cmd),
    .running       (running_c),
    .steady        (steady_c),
    .ready         (standby_ready),
    .trip_qual     (trip_c),
    .fan_warn      (fan_warn_c),
    .brake         (brake_set),
    .cond          (relay_c)
  );

  sos_cond_mux u_out2_mux (
    .func_sel      (output2_function_select),
    .over_volt     (over_volt_c),
    .low_volt_trip (low_trip_c),
    .lost_cmd      (lost_cmd),
    .running       (running_c),
    .steady        (steady_c),
    .ready         (standby_ready),
    .trip_qual     (trip_c),
    .fan_warn      (fan_warn_c),
    .brake         (brake_set),
    .cond          (out2_c)
  );

  // ----------------------------------------------------------------
  // next state and register
  // ----------------------------------------------------------------
  // outputs re-evaluate every cycle
  always_comb
  begin
    st_d       = st_q;
    st_d.relay = relay_c;
    st_d.out2  = out2_c;
  end

  // reset clears both outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q.relay <= OUT_RESET;
      st_q.out2  <= OUT_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign relay_out        = st_q.relay;
  assign multi_output_pin = st_q.out2;

  // ----------------------------------------------------------------
  // code decoding for the checks
  // ----------------------------------------------------------------
  // true for the ten codes that select a condition; all others read low
  function automatic logic code_defined(input logic [FUNC_W-1:0] code);
    case (code)
      FN_OVER_VOLT, FN_LOW_VOLT, FN_LOST_CMD, FN_RUN, FN_STOP: code_defined = 1'h1;
      FN_STEADY, FN_READY, FN_TRIP, FN_FAN_WARN, FN_BRAKE:      code_defined = 1'h1;
      default:                                                  code_defined = 1'h0;
    endcase
  endfunction : code_defined

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_over_volt_out: assert property (
    (relay_function_select == FN_OVER_VOLT) ##1 $stable(relay_function_select)
      |-> relay_out == $past(dc_bus_volts > OVER_VOLT_LEVEL))
    else $error("over-voltage relay mismatch");

  a_low_volt_out: assert property (
    (relay_function_select == FN_LOW_VOLT) && !low_volt_trip |=> !relay_out)
    else $error("low-voltage relay set without trip");

  a_lost_cmd_out: assert property (
    (output2_function_select == FN_LOST_CMD) |=> multi_output_pin == $past(lost_cmd))
    else $error("lost command output mismatch");

  a_run_out: assert property (
    (relay_function_select == FN_RUN) |=> relay_out == $past(run_cmd & volt_out))
    else $error("run relay mismatch");

  a_stop_out: assert property (
    (relay_function_select == FN_STOP) && run_cmd && volt_out |=> !relay_out)
    else $error("stop relay set while running");

  a_steady_out: assert property (
    (output2_function_select == FN_STEADY) && (accel || decel) |=> !multi_output_pin)
    else $error("steady output set during ramp");

  a_ready_out: assert property (
    (relay_function_select == FN_READY) |=> relay_out == $past(standby_ready))
    else $error("ready relay mismatch");

  a_trip_no_lv: assert property (
    (relay_function_select == FN_TRIP) && (trip_output_mode == TRIP_MODE_NO_LV)
      && !other_trip |=> !relay_out)
    else $error("trip relay set on low-voltage only");

  a_trip_out: assert property (
    (relay_function_select == FN_TRIP) && other_trip |=> relay_out)
    else $error("trip relay missed a trip");

  a_fan_warn_out: assert property (
    (output2_function_select == FN_FAN_WARN) && fan_fault_action |=> !multi_output_pin)
    else $error("fan warning while stop action");

  a_brake_out: assert property (
    (output2_function_select == FN_BRAKE) |=> multi_output_pin == $past(brake_set))
    else $error("brake output mismatch");

  a_undef_low: assert property (
    (relay_function_select == 5'h0F) |=> !relay_out)
    else $error("undefined code drove relay");

  // ----------------------------------------------------------------
  // checks: exact follow on each output of the conditions not already followed exactly above
  // ----------------------------------------------------------------
  // relay: each level must equal the condition one edge earlier
  a_lost_relay: assert property (
    (relay_function_select == FN_LOST_CMD) |=> relay_out == $past(lost_cmd))
    else $error("lost command relay mismatch");

  a_low_volt_set: assert property (
    (relay_function_select == FN_LOW_VOLT)
      |=> relay_out == $past((dc_bus_volts < under_volt_level) && low_volt_trip))
    else $error("low-voltage relay mismatch");

  a_stop_exact: assert property (
    (relay_function_select == FN_STOP) |=> relay_out == $past(!(run_cmd && volt_out)))
    else $error("stop relay mismatch");

  a_steady_exact: assert property (
    (relay_function_select == FN_STEADY)
      |=> relay_out == $past(run_cmd && volt_out && !accel && !decel))
    else $error("steady relay mismatch");

  a_trip_all_modes: assert property (
    (relay_function_select == FN_TRIP) && (trip_output_mode != TRIP_MODE_NO_LV)
      |=> relay_out == $past(other_trip || low_volt_trip))
    else $error("trip relay mismatch in all-trip mode");

  a_trip_mode_two: assert property (
    (relay_function_select == FN_TRIP) && (trip_output_mode == TRIP_MODE_NO_LV)
      |=> relay_out == $past(other_trip))
    else $error("trip relay mismatch in mode two");

  a_fan_warn_set: assert property (
    (relay_function_select == FN_FAN_WARN)
      |=> relay_out == $past(fan_fault && (fan_fault_action == FAN_CONTINUE)))
    else $error("fan warning relay mismatch");

  a_brake_relay: assert property (
    (relay_function_select == FN_BRAKE) |=> relay_out == $past(brake_set))
    else $error("brake relay mismatch");

  // second output: same conditions through its own selector
  a_over_volt_out2: assert property (
    (output2_function_select == FN_OVER_VOLT)
      |=> multi_output_pin == $past(dc_bus_volts > OVER_VOLT_LEVEL))
    else $error("over-voltage output 2 mismatch");

  a_low_volt_out2: assert property (
    (output2_function_select == FN_LOW_VOLT)
      |=> multi_output_pin == $past((dc_bus_volts < under_volt_level) && low_volt_trip))
    else $error("low-voltage output 2 mismatch");

  a_run_out2: assert property (
    (output2_function_select == FN_RUN)
      |=> multi_output_pin == $past(run_cmd && volt_out))
    else $error("run output 2 mismatch");

  a_stop_out2: assert property (
    (output2_function_select == FN_STOP)
      |=> multi_output_pin == $past(!(run_cmd && volt_out)))
    else $error("stop output 2 mismatch");

  a_steady_out2: assert property (
    (output2_function_select == FN_STEADY)
      |=> multi_output_pin == $past(run_cmd && volt_out && !accel && !decel))
    else $error("steady output 2 mismatch");

  a_ready_out2: assert property (
    (output2_function_select == FN_READY)
      |=> multi_output_pin == $past(standby_ready))
    else $error("ready output 2 mismatch");

  a_trip_out2: assert property (
    (output2_function_select == FN_TRIP)
      |=> multi_output_pin == $past((trip_output_mode == TRIP_MODE_NO_LV) ? other_trip
                                    : (other_trip || low_volt_trip)))
    else $error("trip output 2 mismatch");

  a_fan_warn_out2: assert property (
    (output2_function_select == FN_FAN_WARN)
      |=> multi_output_pin == $past(fan_fault && (fan_fault_action == FAN_CONTINUE)))
    else $error("fan warning output 2 mismatch");

  // undefined codes, reset and independence of the two selectors
  a_undef_relay: assert property (
    !code_defined(relay_function_select) |=> !relay_out)
    else $error("undefined code drove relay");

  a_undef_out2: assert property (
    !code_defined(output2_function_select) |=> !multi_output_pin)
    else $error("undefined code drove output 2");

  a_reset_clears: assert property (
    disable iff (1'h0) rst |=> !relay_out && !multi_output_pin)
    else $error("outputs not cleared by reset");

  a_pair_indep: assert property (
    (relay_function_select == FN_RUN) && (output2_function_select == FN_STOP)
      |=> relay_out != multi_output_pin)
    else $error("run and stop outputs not complementary");

  // main scenarios reached
  c_trip_relay: cover property ((relay_function_select == FN_TRIP) ##1 relay_out);
  c_run_relay:  cover property ((relay_function_select == FN_RUN) ##1 relay_out);
  c_brake_out2: cover property ((output2_function_select == FN_BRAKE) ##1 multi_output_pin);
  c_fan_out2:   cover property ((output2_function_select == FN_FAN_WARN) ##1 multi_output_pin);
  c_both_on:    cover property (relay_out && multi_output_pin);

endmodule : sos_selector

// file: dv/sos_field_model.sv
// field wiring model: loads on the relay and the second output, counting closures
`timescale 1ns/1ns
module sos_field_model
(
  input  wire logic        clk,            // control clock
  input  wire logic        rst,            // sync reset, high
  input  wire logic        relay_out,      // relay coil drive
  input  wire logic        multi_output_pin, // second output drive
  output int               relay_closures, // relay contact closures seen
  output int               out2_closures   // output 2 load switch-ons seen
);
  logic relay_q;                           // last relay level
  logic out2_q;                            // last output 2 level

  // count each rising level as one closure of the external load
  always @(posedge clk)
  begin
    if (rst)
    begin
      relay_q        <= 1'h0;
      out2_q         <= 1'h0;
      relay_closures <= 0;
      out2_closures  <= 0;
    end
    else
    begin
      relay_q <= relay_out;
      out2_q  <= multi_output_pin;
      if (relay_out === 1'h1 && relay_q === 1'h0) relay_closures <= relay_closures + 1;
      if (multi_output_pin === 1'h1 && out2_q === 1'h0) out2_closures <= out2_closures + 1;
    end
  end
endmodule : sos_field_model

// file: dv/tb.sv
// self-checking testbench for the status output selector
`timescale 1ns/1ns
module tb;
  import sos_pkg::*;
  logic       clk = 1'h0, rst = 1'h1;          // clock and sync reset
  logic [4:0] rsel = 5'h00, osel = 5'h00;      // relay and output 2 codes
  logic [1:0] trip_output_mode = 2'h0;         // trip qualification
  logic       fan_fault_action = 1'h1;         // fan fault action
  logic [9:0] dc_bus_volts = 10'h100;          // bus reading
  logic [9:0] under_volt_level = UNDER_VOLT_DEFAULT; // low-voltage level
  logic       low_volt_trip = 1'h0, other_trip = 1'h0, lost_cmd = 1'h0;   // status flags
  logic       run_cmd = 1'h0, volt_out = 1'h0, accel = 1'h0, decel = 1'h0; // drive state
  logic       standby_ready = 1'h0, fan_fault = 1'h0, brake_set = 1'h0;   // more status
  logic       relay_out, multi_output_pin;     // outputs under test
  logic [1:0] exp_q[$];                        // expected {relay, out2} per edge
  logic [1:0] exp_now;                         // note taken off the queue
  int         fail_count = 0, cmp_count = 0, rc, oc; // counters
  int         exp_rc = 0, exp_oc = 0;          // closures expected so far
  logic [1:0] exp_last = 2'h0;                 // expected levels of the previous edge
  always #25 clk = ~clk;                       // 20 MHz clock

  sos_selector sos_selector_i (.clk(clk), .rst(rst), .relay_function_select(rsel),
    .output2_function_select(osel), .trip_output_mode(trip_output_mode),
    .fan_fault_action(fan_fault_action), .dc_bus_volts(dc_bus_volts),
    .under_volt_level(under_volt_level), .low_volt_trip(low_volt_trip),
    .other_trip(other_trip), .lost_cmd(lost_cmd), .run_cmd(run_cmd), .volt_out(volt_out),
    .accel(accel), .decel(decel), .standby_ready(standby_ready), .fan_fault(fan_fault),
    .brake_set(brake_set), .relay_out(relay_out), .multi_output_pin(multi_output_pin));
  sos_field_model sos_field_model_i (.clk(clk), .rst(rst), .relay_out(relay_out),
    .multi_output_pin(multi_output_pin), .relay_closures(rc), .out2_closures(oc));

  // expected level for one code, worked out from the current inputs
  function automatic logic cond_of(input logic [4:0] c);
    logic run;
    run = run_cmd & volt_out;
    case (c)
      5'h08: cond_of = dc_bus_volts > 10'h19A;
      5'h09: cond_of = (dc_bus_volts < under_volt_level) & low_volt_trip;
      5'h0B: cond_of = lost_cmd;
      5'h0C: cond_of = run;
      5'h0D: cond_of = ~run;
      5'h0E: cond_of = run & ~accel & ~decel;
      5'h10: cond_of = standby_ready;
      5'h11: cond_of = (trip_output_mode == 2'h2) ? other_trip : other_trip | low_volt_trip;
      5'h12: cond_of = fan_fault & (fan_fault_action == 1'h0);
      5'h13: cond_of = brake_set;
      default: cond_of = 1'h0;
    endcase
  endfunction : cond_of

  // compare one value and count it
  task check(input logic seen, input logic exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t %s seen %b expected %b", $time, what, seen, exp);
    end
  endtask : check

  // note the expected result of the coming edge, then move to the next falling edge
  task go(input int n);
    repeat (n)
    begin
      exp_q.push_back({cond_of(rsel), cond_of(osel)});
      @(negedge clk);
    end
  endtask : go

  // random status inputs, bus reading often placed at a threshold
  task rnd_in();
    {low_volt_trip, other_trip, lost_cmd, run_cmd, volt_out} = 5'($urandom);
    {accel, decel, standby_ready, fan_fault, brake_set} = 5'($urandom);
    trip_output_mode = 2'($urandom);
    fan_fault_action = 1'($urandom);
    case ($urandom % 3)
      0: dc_bus_volts = 10'h199 + 10'($urandom % 3);
      1: dc_bus_volts = under_volt_level - 10'h001 + 10'($urandom % 3);
      default: dc_bus_volts = 10'($urandom);
    endcase
  endtask : rnd_in

  // print counts and verdict, then stop
  task results();
    $display("comparisons %0d mismatches %0d closures %0d/%0d", cmp_count, fail_count, rc, oc);
    if (fail_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // output watcher: zero during reset, else the oldest note
  always @(posedge clk)
  begin
    #1;
    if (rst)
    begin
      check(relay_out, OUT_RESET, "relay in reset");
      check(multi_output_pin, OUT_RESET, "out2 in reset");
      exp_rc = 0;
      exp_oc = 0;
      exp_last = 2'h0;
    end
    else if (exp_q.size() > 0)
    begin
      exp_now = exp_q.pop_front();
      check(relay_out, exp_now[1], "relay");
      check(multi_output_pin, exp_now[0], "out2");
      check(rc == exp_rc, 1'h1, "relay closures");
      check(oc == exp_oc, 1'h1, "out2 closures");
      exp_rc += int'(exp_now[1] & ~exp_last[1]);
      exp_oc += int'(exp_now[0] & ~exp_last[0]);
      exp_last = exp_now;
    end
  end

  // watchdog against a hang
  initial
  begin
    #(2000 * 50);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end

  // main sequence
  initial
  begin
    void'($urandom(32'hC7F16499));
    repeat (6) @(negedge clk);
    rst = 1'h0;
    rsel = FN_RUN;
    osel = FN_STOP;
    run_cmd = 1'h1;
    volt_out = 1'h1;
    go(1);
    run_cmd = 1'h0;
    go(1);
    $display("test run and stop walk done");
    for (int c = 0; c < 32; c++)
    begin
      rsel = 5'(c);
      osel = 5'(31 - c);
      under_volt_level = UNDER_VOLT_DEFAULT + 10'($urandom % 16);
      repeat (8)
      begin
        rnd_in();
        go(1);
      end
    end
    $display("test code sweep done");
    rsel = FN_TRIP;
    osel = FN_FAN_WARN;
    for (int m = 0; m < 8; m++)
      for (int t = 0; t < 4; t++)
      begin
        trip_output_mode = 2'(m);
        fan_fault_action = 1'(m >> 2);
        {low_volt_trip, other_trip} = 2'(t);
        fan_fault = 1'h1;
        go(1);
      end
    $display("test trip modes and fan action done");
    rst = 1'h1;
    repeat (3) @(negedge clk);
    rst = 1'h0;
    rsel = FN_BRAKE;
    osel = FN_OVER_VOLT;
    repeat (6)
    begin
      rnd_in();
      go(1);
    end
    $display("test reset in mid run done");
    results();
  end
endmodule : tb
